// [rtl/cms_pkg.sv]
// Package with constants and types for the cipher mode switch controller.
package cms_pkg;
   // ==========================================
   // Handshake timing, in frames
   // ==========================================
   localparam int CMS_REQ_TRIES = 5;
   localparam int CMS_CONF_LAST_OFS = 11;
   localparam logic [3:0] CMS_CNT_ZERO = 4'h0;
   localparam logic [3:0] CMS_CNT_ONE = 4'h1;
   // ==========================================
   // Keystream segment layout
   // ==========================================
   localparam int CMS_A_TAIL_BITS = 40;
   localparam int CMS_SUB_DATA_BITS = 64;
   localparam int CMS_SUB_CHECK_BITS = 16;
   localparam int CMS_SUB_BITS = CMS_SUB_DATA_BITS + CMS_SUB_CHECK_BITS;
   localparam int CMS_J_LONG = 672;
   localparam int CMS_J_DEFAULT = 672;
   // ==========================================
   // Types
   // ==========================================
   typedef enum logic [1:0] {
      CMS_FMT_UNPROT,
      CMS_FMT_MULTI,
      CMS_FMT_CODED
   } cms_fmt_type;
   typedef enum logic [1:0] {
      CMS_MSG_NONE,
      CMS_MSG_HALT_REQ,
      CMS_MSG_HALT_CONFIRM,
      CMS_MSG_HALT_GRANT
   } cms_msg_type;
   typedef struct packed {
      logic strobe;
      logic [3:0] frame_num_low;
      cms_msg_type msg;
   } cms_frame_type;
endpackage

// [rtl/cms_frame_track.sv]
// Frame parity tracker and handshake frame counter.
`timescale 1ns/1ps
module cms_frame_track
   import cms_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Frame tick and control
   input wire logic i_frame_tick,
   input wire logic i_frame_odd,
   input wire logic i_clear,
   // Status
   output logic o_even_tick,
   output logic o_odd_tick,
   output logic [3:0] o_count
);
   // ==========================================
   // Parity split and frame count
   // ==========================================
   assign o_even_tick = i_frame_tick & ~i_frame_odd;
   assign o_odd_tick = i_frame_tick & i_frame_odd;
   always_ff @(posedge i_clk) begin
      if (i_rst || i_clear) begin
         o_count <= CMS_CNT_ZERO;
      end else if (i_frame_tick && o_count != 4'hF) begin
         o_count <= o_count + CMS_CNT_ONE;
      end
   end
endmodule

// [rtl/cms_ks_mask.sv]
// Keystream bit mask for half-slot and long-slot formats.
`timescale 1ns/1ps
module cms_ks_mask
   import cms_pkg::*;
#(
   parameter int J_BITS = CMS_J_DEFAULT
)(
   // Format selection
   input wire logic [1:0] i_fmt,
   input wire logic i_tail_is_ct,
   input wire logic i_padding,
   input wire logic [9:0] i_coded_bits,
   // Mask over the segment, bit k set means keystream bit k is applied
   output logic [J_BITS+CMS_A_TAIL_BITS-1:0] o_mask
);
   localparam int SEG = J_BITS + CMS_A_TAIL_BITS;
   localparam int PAD_BITS = 4;
   if (J_BITS < CMS_SUB_BITS || J_BITS > 1000) begin : g_bad_size
      $error("cms_ks_mask: unsupported B-field size");
   end
   // The A-field tail is covered when i_tail_is_ct; multi-subfield format skips the first subfield's check bits and, at the long-slot size only, set padding.
   genvar k;
   generate
      for (k = 0; k < SEG; k++) begin : g_bit
         localparam int B = k - CMS_A_TAIL_BITS;
         localparam bit IS_CHECK = (B >= 0) &&
            ((B % CMS_SUB_BITS) >= CMS_SUB_DATA_BITS) && (B < CMS_SUB_BITS);
         localparam bit IS_PAD = (J_BITS == CMS_J_LONG) && (B >= J_BITS - PAD_BITS);
         if (k < CMS_A_TAIL_BITS) begin : g_tail
            assign o_mask[k] = i_tail_is_ct;
         end else begin : g_b
            assign o_mask[k] =
               (i_fmt == 2'(CMS_FMT_UNPROT)) ||
               (i_fmt == 2'(CMS_FMT_MULTI) && !IS_CHECK &&
                !(IS_PAD && i_padding)) ||
               (i_fmt == 2'(CMS_FMT_CODED) && 10'(B) < i_coded_bits);
         end
      end
   endgenerate
endmodule

// [rtl/cms_ctrl.sv]
// Cipher mode switch controller top for either radio end.
`timescale 1ns/1ps
module cms_ctrl
   import cms_pkg::*;
#(
   parameter int J_BITS = CMS_J_DEFAULT
)(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Role and frame timing
   input wire logic i_is_fixed,
   input wire logic i_frame_tick,
   input wire logic i_frame_odd,
   input wire logic [23:0] i_frame_num,
   // Upper layer
   input wire logic i_mode_switch_request_primitive,
   input wire logic i_rekey,
   input wire logic i_new_bearer,
   input wire logic i_handover_second,
   input wire logic i_default_encryption,
   input wire logic i_start_accept,
   output logic o_mode_switch_confirm_primitive,
   output logic o_mode_switch_indication_primitive,
   output logic o_link_release_indication,
   output logic o_cipher_begin_request,
   // Peer messages
   input wire cms_msg_type i_rx_msg,
   output cms_msg_type o_tx_msg,
   output logic o_tx_msg_clear,
   // Data path control
   input wire logic [1:0] i_fmt,
   input wire logic i_tail_is_ct,
   input wire logic i_padding,
   input wire logic [9:0] i_coded_bits,
   output logic o_rx_decrypt,
   output logic o_tx_encrypt,
   output logic o_rx_discard,
   output logic o_bearer_encrypted,
   output logic o_conn2_encrypted,
   output logic o_ks_reinit,
   output logic [23:0] o_ks_iv,
   output logic [J_BITS+CMS_A_TAIL_BITS-1:0] o_ks_mask
);
   typedef enum logic [2:0] {
      CMS_ST_CIPHER,
      CMS_ST_REQ,
      CMS_ST_GRANT,
      CMS_ST_CONF,
      CMS_ST_CLEAR
   } cms_state_type;
   if (J_BITS < CMS_SUB_BITS) begin : g_bad_size
      $error("cms_ctrl: B-field too small");
   end
   cms_state_type state;
   logic even_tick;
   logic odd_tick;
   logic [3:0] count;
   logic clear_cnt;
   logic rx_halt_req;
   logic rx_confirm;
   logic rx_grant;
   logic rekey_pending;
   // ==========================================
   // Frame tracking
   // ==========================================
   assign rx_halt_req = i_frame_tick && i_rx_msg == CMS_MSG_HALT_REQ;
   assign rx_confirm = i_frame_tick && i_rx_msg == CMS_MSG_HALT_CONFIRM;
   assign rx_grant = i_frame_tick && i_rx_msg == CMS_MSG_HALT_GRANT;
   assign clear_cnt = (state == CMS_ST_CIPHER) || (state == CMS_ST_CLEAR) ||
      (state == CMS_ST_REQ && count == CMS_CNT_ZERO && odd_tick);
   cms_frame_track u_track (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_frame_tick(i_frame_tick),
      .i_frame_odd(i_frame_odd),
      .i_clear(clear_cnt),
      .o_even_tick(even_tick),
      .o_odd_tick(odd_tick),
      .o_count(count)
   );
   // ==========================================
   // Handshake state machine
   // ==========================================
   // The count runs on every frame, so N sends span 2N frames up to the tick
   // that closes the window. The portable side holds it at zero until its
   // first even frame, so the window does not depend on the entry parity.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state <= CMS_ST_CIPHER;
      end else begin
         case (state)
            CMS_ST_CIPHER: begin
               if (i_is_fixed && rx_halt_req && !i_frame_odd) begin
                  state <= CMS_ST_CONF;
               end else if (!i_is_fixed && i_mode_switch_request_primitive) begin
                  state <= CMS_ST_REQ;
               end
            end
            CMS_ST_REQ: begin
               if (rx_confirm) begin
                  state <= CMS_ST_GRANT;
               end else if (even_tick && count >= 4'(2 * CMS_REQ_TRIES)) begin
                  state <= CMS_ST_CLEAR;
               end
            end
            CMS_ST_GRANT: begin
               if (even_tick) begin
                  state <= CMS_ST_CLEAR;
               end
            end
            CMS_ST_CONF: begin
               if (rx_grant) begin
                  state <= CMS_ST_CLEAR;
               end else if (even_tick && count >= 4'(CMS_CONF_LAST_OFS)) begin
                  state <= CMS_ST_CLEAR;
               end
            end
            CMS_ST_CLEAR: begin
               if (i_start_accept) begin
                  state <= CMS_ST_CIPHER;
               end
            end
            default: state <= CMS_ST_CIPHER;
         endcase
      end
   end
   // ==========================================
   // Upper layer events
   // ==========================================
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_mode_switch_confirm_primitive <= 1'b0;
         o_mode_switch_indication_primitive <= 1'b0;
         o_link_release_indication <= 1'b0;
      end else begin
         o_mode_switch_confirm_primitive <= state == CMS_ST_REQ && rx_confirm;
         o_mode_switch_indication_primitive <= state == CMS_ST_CONF && rx_grant;
         o_link_release_indication <=
            (state == CMS_ST_REQ && !rx_confirm && even_tick &&
             count >= 4'(2 * CMS_REQ_TRIES)) ||
            (state == CMS_ST_CONF && !rx_grant && even_tick &&
             count >= 4'(CMS_CONF_LAST_OFS));
      end
   end
   // Re-keying is remembered at the request and fires once the confirm lands.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rekey_pending <= 1'b0;
         o_cipher_begin_request <= 1'b0;
      end else begin
         if (state == CMS_ST_CIPHER && i_mode_switch_request_primitive) begin
            rekey_pending <= i_rekey;
         end else if (state == CMS_ST_REQ && rx_confirm) begin
            rekey_pending <= 1'b0;
         end
         o_cipher_begin_request <= rekey_pending && state == CMS_ST_REQ && rx_confirm;
      end
   end
   // ==========================================
   // Message transmit
   // ==========================================
   always_comb begin
      o_tx_msg = CMS_MSG_NONE;
      if (!i_is_fixed && even_tick) begin
         if (state == CMS_ST_REQ && count < 4'(2 * CMS_REQ_TRIES)) begin
            o_tx_msg = CMS_MSG_HALT_REQ;
         end else if (state == CMS_ST_GRANT) begin
            o_tx_msg = CMS_MSG_HALT_GRANT;
         end
      end else if (i_is_fixed && odd_tick && state == CMS_ST_CONF && !rx_grant) begin
         o_tx_msg = CMS_MSG_HALT_CONFIRM;
      end
   end
   assign o_tx_msg_clear = 1'b1;
   // ==========================================
   // Data path mode
   // ==========================================
   always_comb begin
      o_rx_decrypt = 1'b0;
      o_tx_encrypt = 1'b0;
      o_rx_discard = 1'b0;
      case (state)
         CMS_ST_CIPHER: begin
            o_rx_decrypt = 1'b1;
            o_tx_encrypt = 1'b1;
         end
         CMS_ST_REQ: begin
            o_rx_decrypt = !rx_confirm;
            o_tx_encrypt = 1'b1;
            o_rx_discard = !rx_confirm;
         end
         CMS_ST_GRANT: begin
            o_tx_encrypt = !even_tick;
         end
         CMS_ST_CONF: begin
            o_rx_decrypt = !rx_grant && count == CMS_CNT_ZERO;
            o_rx_discard = !rx_grant && count != CMS_CNT_ZERO;
         end
         CMS_ST_CLEAR: begin
         end
         default: begin
         end
      endcase
   end
   // New bearers copy the connection mode; handover leg two starts clear.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_bearer_encrypted <= 1'b0;
         o_conn2_encrypted <= 1'b0;
      end else begin
         if (i_new_bearer) begin
            o_bearer_encrypted <= state != CMS_ST_CLEAR;
         end
         if (!i_handover_second) begin
            o_conn2_encrypted <= 1'b0;
         end else if (i_start_accept && (i_default_encryption || !i_is_fixed)) begin
            o_conn2_encrypted <= 1'b1;
         end
      end
   end
   // ==========================================
   // Keystream generator control
   // ==========================================
   // One shared IV feeds every bearer and both handover legs, so all use one pair.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_ks_reinit <= 1'b0;
         o_ks_iv <= 24'h000000;
      end else begin
         o_ks_reinit <= i_frame_tick && state != CMS_ST_CLEAR;
         if (i_frame_tick) begin
            o_ks_iv <= i_frame_num;
         end
      end
   end
   cms_ks_mask #(
      .J_BITS(J_BITS)
   ) u_mask (
      .i_fmt(i_fmt),
      .i_tail_is_ct(i_tail_is_ct),
      .i_padding(i_padding),
      .i_coded_bits(i_coded_bits),
      .o_mask(o_ks_mask)
   );
   // ==========================================
   // Checks
   // ==========================================
   AST_PT_EVEN_ONLY: assert property (@(posedge i_clk) disable iff (i_rst)
      (!i_is_fixed && o_tx_msg != CMS_MSG_NONE) |-> !i_frame_odd)
      else $error("portable sent in odd frame");
   AST_FT_ODD_ONLY: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_is_fixed && o_tx_msg != CMS_MSG_NONE) |-> i_frame_odd)
      else $error("fixed sent in even frame");
   AST_CONFIRM_REPORT: assert property (@(posedge i_clk) disable iff (i_rst)
      (state == CMS_ST_REQ && rx_confirm) |=> o_mode_switch_confirm_primitive)
      else $error("confirm not reported");
   AST_GRANT_REPORT: assert property (@(posedge i_clk) disable iff (i_rst)
      (state == CMS_ST_CONF && rx_grant) |=> o_mode_switch_indication_primitive
         && state == CMS_ST_CLEAR)
      else $error("grant not indicated");
   AST_DISCARD_REQ: assert property (@(posedge i_clk) disable iff (i_rst)
      (state == CMS_ST_REQ && !rx_confirm) |-> o_rx_discard)
      else $error("data not discarded");
   AST_STOP_DECRYPT: assert property (@(posedge i_clk) disable iff (i_rst)
      (state == CMS_ST_REQ && rx_confirm) |-> !o_rx_decrypt ##1 state == CMS_ST_GRANT)
      else $error("decrypt not stopped on confirm");
   AST_GRANT_SENT: assert property (@(posedge i_clk) disable iff (i_rst)
      (state == CMS_ST_GRANT && even_tick) |-> o_tx_msg == CMS_MSG_HALT_GRANT
         && !o_tx_encrypt)
      else $error("grant frame wrong");
   AST_RELEASE_PULSE: assert property (@(posedge i_clk) disable iff (i_rst)
      o_link_release_indication |-> state == CMS_ST_CLEAR && !$past(rx_confirm)
         && !$past(rx_grant))
      else $error("release without timeout");
   AST_FT_CLEAR_TX: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_is_fixed && state == CMS_ST_CONF) |-> !o_tx_encrypt)
      else $error("fixed still encrypting");
endmodule

// [dv/cms_peer.sv]
// Peer radio end model for the cipher mode switch controller.
`timescale 1ns/1ps
module cms_peer
   import cms_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Frame timing and control
   input wire logic i_frame_tick,
   input wire logic i_frame_odd,
   input wire logic i_dut_fixed,
   input wire logic i_start,
   input wire logic [3:0] i_delay,
   // Messages
   input wire cms_msg_type i_tx_msg,
   output cms_msg_type o_rx_msg
);
   // ==========================================
   // Reply scheduling
   // ==========================================
   // A delay of 15 stops the peer's confirm and grant replies, which is how the timeout paths are reached.
   logic pend;
   logic go;
   logic [3:0] wait_cnt;
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pend <= 1'b0;
         go <= 1'b0;
         wait_cnt <= 4'h0;
         o_rx_msg <= CMS_MSG_NONE;
      end else if (i_start) begin
         go <= i_dut_fixed;
         pend <= 1'b0;
         wait_cnt <= i_delay;
      end else if (i_frame_tick) begin
         o_rx_msg <= CMS_MSG_NONE;
         if (i_dut_fixed == i_frame_odd) begin
            if (go) begin
               o_rx_msg <= CMS_MSG_HALT_REQ;
               go <= 1'b0;
            end else if (i_tx_msg != CMS_MSG_HALT_GRANT && (pend ||
                  i_tx_msg == CMS_MSG_HALT_REQ || i_tx_msg == CMS_MSG_HALT_CONFIRM)) begin
               pend <= !i_dut_fixed;
               if (wait_cnt != 4'h0) begin
                  wait_cnt <= wait_cnt - 4'h1;
               end else if (i_delay != 4'hF) begin
                  o_rx_msg <= i_dut_fixed ? CMS_MSG_HALT_GRANT : CMS_MSG_HALT_CONFIRM;
               end
            end
         end
         if (i_tx_msg == CMS_MSG_HALT_GRANT) begin
            pend <= 1'b0;
         end
      end
   end
endmodule

// [dv/tb_top.sv]
// Self-checking testbench for the cipher mode switch controller.
`timescale 1ns/1ps
module tb_top
   import cms_pkg::*;
;
   logic i_clk, i_rst, i_is_fixed, i_frame_tick, i_frame_odd, i_rekey, i_tail_is_ct, i_padding;
   logic [23:0] i_frame_num, last_num;
   logic [3:0] pls, delay;
   logic [2:0] cyc;
   logic [1:0] i_fmt;
   logic [9:0] i_coded_bits;
   cms_msg_type i_rx_msg, o_tx_msg;
   logic o_cfm, o_ind, o_rel, o_beg, o_tx_msg_clear, o_rx_decrypt, o_tx_encrypt, o_rx_discard;
   logic o_bearer_encrypted, o_ks_reinit;
   logic i_handover_second, i_default_encryption, o_conn2_encrypted;
   logic [23:0] o_ks_iv;
   logic [711:0] o_ks_mask;
   int bad_count, total_checks, n_req, n_conf;
   wire [3:0] pulses = {o_beg, o_rel, o_ind, o_cfm};
   cms_ctrl dut (.i_clk(i_clk), .i_rst(i_rst), .i_is_fixed(i_is_fixed),
      .i_frame_tick(i_frame_tick), .i_frame_odd(i_frame_odd), .i_frame_num(i_frame_num),
      .i_mode_switch_request_primitive(pls[0]), .i_rekey(i_rekey), .i_new_bearer(pls[1]),
      .i_handover_second(i_handover_second), .i_default_encryption(i_default_encryption),
      .i_start_accept(pls[2]),
      .o_mode_switch_confirm_primitive(o_cfm), .o_mode_switch_indication_primitive(o_ind),
      .o_link_release_indication(o_rel), .o_cipher_begin_request(o_beg),
      .i_rx_msg(i_rx_msg), .o_tx_msg(o_tx_msg), .o_tx_msg_clear(o_tx_msg_clear),
      .i_fmt(i_fmt), .i_tail_is_ct(i_tail_is_ct), .i_padding(i_padding),
      .i_coded_bits(i_coded_bits), .o_rx_decrypt(o_rx_decrypt), .o_tx_encrypt(o_tx_encrypt),
      .o_rx_discard(o_rx_discard), .o_bearer_encrypted(o_bearer_encrypted),
      .o_conn2_encrypted(o_conn2_encrypted), .o_ks_reinit(o_ks_reinit), .o_ks_iv(o_ks_iv),
      .o_ks_mask(o_ks_mask));
   cms_peer peer (.i_clk(i_clk), .i_rst(i_rst), .i_frame_tick(i_frame_tick),
      .i_frame_odd(i_frame_odd), .i_dut_fixed(i_is_fixed), .i_start(pls[3]),
      .i_delay(delay), .i_tx_msg(o_tx_msg), .o_rx_msg(i_rx_msg));
   // ==========================================
   // Clock, frames and monitor
   // ==========================================
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc <= cyc + 3'h1;
      i_frame_tick <= (cyc == 3'h7);
      if (i_frame_tick) begin
         i_frame_num <= i_frame_num + 24'h1;
         i_frame_odd <= ~i_frame_odd;
         last_num <= i_frame_num;
      end
      if (!i_rst && o_ks_reinit) check("iv", 32'(last_num), 32'(o_ks_iv));
      if (!i_rst && i_frame_tick && o_tx_msg !== CMS_MSG_NONE) begin
         check("tx parity", 32'(i_is_fixed), 32'(i_frame_odd));
         check("tx clear", 32'h1, 32'(o_tx_msg_clear));
         if (o_tx_msg === CMS_MSG_HALT_REQ) n_req++;
         if (o_tx_msg === CMS_MSG_HALT_CONFIRM) n_conf++;
      end
   end
   // ==========================================
   // Shared tasks
   // ==========================================
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic pulse(input int k);
      @(posedge i_clk);
      pls[k] <= 1'b1;
      @(posedge i_clk);
      pls[k] <= 1'b0;
      #1;
   endtask
   // Bounded waits; running out of cycles ends the run as a failure.
   task automatic wait_sig(input int k, input string name);
      int n;
      n = 0;
      while (pulses[k] !== 1'b1 && n < 300) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      check(name, 32'h1, 32'(pulses[k]));
      if (n >= 300) final_report();
   endtask
   task automatic wait_tx(input cms_msg_type m);
      int n;
      n = 0;
      while (!(i_frame_tick === 1'b1 && o_tx_msg === m) && n < 300) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      check("tx msg", 32'(m), 32'(o_tx_msg));
      if (n >= 300) begin
         bad_count++;
         final_report();
      end
   endtask
   // ==========================================
   // Scenarios
   // ==========================================
   task automatic t_port(input logic [3:0] dly, input logic rk);
      @(posedge i_clk);
      i_is_fixed <= 1'b0;
      delay <= dly;
      i_rekey <= rk;
      pulse(3);
      n_req = 0;
      pulse(0);
      @(posedge i_clk);
      #1;
      check("discard", 32'h1, 32'(o_rx_discard));
      if (dly == 4'hF) begin
         wait_sig(2, "release");
         check("req count", 32'h5, 32'(n_req));
      end else begin
         wait_sig(0, "confirm");
         check("decrypt", 32'h0, 32'(o_rx_decrypt));
         check("discard end", 32'h0, 32'(o_rx_discard));
         check("req repeats", 32'(dly) + 32'h1, 32'(n_req));
         if (rk) begin
            wait_sig(3, "begin request");
         end else begin
            check("no begin", 32'h0, 32'(o_beg));
         end
         wait_tx(CMS_MSG_HALT_GRANT);
         check("tx encrypt", 32'h0, 32'(o_tx_encrypt));
         pulse(1);
         check("bearer clear", 32'h0, 32'(o_bearer_encrypted));
      end
      pulse(2);
      $display("test portable delay %0d rekey %0d done", dly, rk);
   endtask
   task automatic t_fixed(input logic [3:0] dly);
      @(posedge i_clk);
      i_is_fixed <= 1'b1;
      delay <= dly;
      n_conf = 0;
      pulse(3);
      wait_tx(CMS_MSG_HALT_CONFIRM);
      check("fixed encrypt", 32'h0, 32'(o_tx_encrypt));
      if (dly == 4'hF) begin
         wait_sig(2, "release");
         check("conf count", 32'h6, 32'(n_conf));
      end else begin
         wait_sig(1, "indication");
         check("fixed decrypt", 32'h0, 32'(o_rx_decrypt));
         check("conf repeats", 32'(dly) + 32'h1, 32'(n_conf));
      end
      pulse(2);
      $display("test fixed delay %0d done", dly);
   endtask
   task automatic t_mask();
      pulse(1);
      check("bearer enc", 32'h1, 32'(o_bearer_encrypted));
      check("width", 32'h2C8, 32'($bits(o_ks_mask)));
      check("unprot", 32'h1, 32'(&o_ks_mask));
      @(posedge i_clk);
      i_fmt <= CMS_FMT_MULTI;
      i_tail_is_ct <= 1'b0;
      @(posedge i_clk);
      #1;
      check("tail", 32'h0, 32'(|o_ks_mask[39:0]));
      check("sub data", 32'h1, 32'(&o_ks_mask[103:40]));
      check("sub check", 32'h0, 32'(|o_ks_mask[119:104]));
      check("later subs", 32'h1, 32'(&o_ks_mask[711:120]));
      @(posedge i_clk);
      i_padding <= 1'b1;
      @(posedge i_clk);
      #1;
      check("padding", 32'h0, 32'(|o_ks_mask[711:708]));
      @(posedge i_clk);
      i_fmt <= CMS_FMT_CODED;
      @(posedge i_clk);
      #1;
      check("coded used", 32'h1, 32'(&o_ks_mask[139:40]));
      check("coded rest", 32'h0, 32'(|o_ks_mask[711:140]));
      $display("test mask done");
   endtask
   task automatic t_hand();
      @(posedge i_clk);
      i_handover_second <= 1'b1;
      i_default_encryption <= 1'b1;
      @(posedge i_clk);
      #1;
      check("conn2 start", 32'h0, 32'(o_conn2_encrypted));
      pulse(2);
      check("conn2 fixed", 32'h1, 32'(o_conn2_encrypted));
      @(posedge i_clk);
      i_handover_second <= 1'b0;
      i_is_fixed <= 1'b0;
      i_default_encryption <= 1'b0;
      @(posedge i_clk);
      i_handover_second <= 1'b1;
      @(posedge i_clk);
      #1;
      check("conn2 restart", 32'h0, 32'(o_conn2_encrypted));
      pulse(2);
      check("conn2 portable", 32'h1, 32'(o_conn2_encrypted));
      $display("test handover done");
   endtask
   initial begin
      {i_rst, pls, cyc, i_frame_tick, i_frame_odd, i_frame_num, last_num} = '0;
      {i_is_fixed, i_rekey, i_padding, delay, i_fmt} = '0;
      {i_handover_second, i_default_encryption} = '0;
      i_rst = 1'b1;
      i_tail_is_ct = 1'b1;
      i_coded_bits = 10'h064;
      repeat (12) @(posedge i_clk);
      i_rst <= 1'b0;
      t_mask();
      t_port(4'h0, 1'b0);
      t_port(4'h2, 1'b1);
      t_port(4'hF, 1'b0);
      t_fixed(4'h1);
      t_fixed(4'hF);
      t_hand();
      final_report();
   end
endmodule
